// File: design/sar_pkg.sv
// Shared constants and state types for the converter link
package sar_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RESULT_WIDTH = 16;
  localparam int INIT_WAIT_NS = 20000;
  localparam int INIT_CYCLES =
    (INIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_TIME_NS = 3000;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int ACQ_DELAY_NS = 527;
  localparam int ACQ_CYCLES =
    (ACQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNV_QUIET_NS = 40;
  localparam int CNV_QUIET_CYCLES =
    (CNV_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_MIN_MHZ = 20;
  localparam int SCK_HALF_CYCLES = 4;
  localparam int SCK_PERIOD_CYCLES = 2 * SCK_HALF_CYCLES;
  localparam int GC_LOW_PCT = 10;
  localparam int GC_HIGH_PCT = 90;
  localparam logic [11:0] INIT_LAST = 12'(INIT_CYCLES - 1);
  localparam logic [11:0] CONV_LAST = 12'(CONV_CYCLES - 1);
  localparam logic [11:0] ACQ_FROM = 12'(ACQ_CYCLES);
  localparam logic [2:0] SCK_FALL_PHASE = 3'(SCK_HALF_CYCLES - 1);
  localparam logic [2:0] SCK_LAST_PHASE = 3'(SCK_PERIOD_CYCLES - 1);
  localparam logic [3:0] LAST_BIT = 4'(RESULT_WIDTH - 1);
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CODE_MAX = 16'h7fff;
  localparam logic [15:0] CODE_MIN = 16'h8000;
  localparam logic [11:0] COUNT_RESET = 12'h000;
  localparam int SYNC_CNV = 0;
  localparam int SYNC_SCK = 1;
  localparam int SYNC_SEL = 2;
  localparam int SYNC_STRAP = 3;
  localparam int SYNC_SUPPLY = 4;
  localparam int SYNC_COUNT = 5;
  // Idle pin levels: select and strap high, so no false edge after reset
  localparam logic [SYNC_COUNT-1:0] SYNC_RESET = 5'h0c;

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_DOWN = 3'b010,
    ST_CONV = 3'b100
  } dev_state_type;

  typedef enum logic [4:0] {
    H_INIT = 5'b00001,
    H_IDLE = 5'b00010,
    H_START = 5'b00100,
    H_CONV = 5'b01000,
    H_READ = 5'b10000
  } host_state_type;
endpackage

// File: design/sar_link_if.sv
// Pin-level link between converter and host controller
`timescale 1ns/10ps
interface sar_link_if;
  logic conversionStart;
  logic sck;
  logic readSelectN;
  logic referenceCompressStrapN;
  logic busy;
  logic sdo;
  logic sdoOe;
  logic sdoLine;

  // Undriven data line modelled as pulled high
  assign sdoLine = sdoOe ? sdo : 1'b1;

  modport device (
    input conversionStart,
    input sck,
    input readSelectN,
    input referenceCompressStrapN,
    output busy,
    output sdo,
    output sdoOe
  );

  modport host (
    output conversionStart,
    output sck,
    output readSelectN,
    output referenceCompressStrapN,
    input busy,
    input sdoLine
  );
endinterface

// File: design/sar_adc_device.sv
// Converter end: conversion timing, power state and serial readout
`timescale 1ns/10ps
module sar_adc_device
  import sar_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  sar_link_if.device link,
  input wire logic [15:0] analogSample,
  input wire logic supplyLow,
  output logic poweredDown,
  output logic acquiring,
  output logic initDone,
  output logic gainCompression
);

  function automatic logic [15:0] scale_code(
    input logic [15:0] raw,
    input logic compress
  );
    logic signed [31:0] wide;
    logic [15:0] code;
    wide = 32'(signed'(raw));
    code = raw;
    if (compress) begin
      wide = wide * 100 / (GC_HIGH_PCT - GC_LOW_PCT);
      if (wide > 32'sd32767) begin
        code = CODE_MAX;
      end else if (wide < -32'sd32768) begin
        code = CODE_MIN;
      end else begin
        code = wide[15:0];
      end
    end
    return code;
  endfunction

  logic [SYNC_COUNT-1:0] syncA;
  logic [SYNC_COUNT-1:0] syncB;
  logic [SYNC_COUNT-1:0] syncPrev;
  logic [SYNC_COUNT-1:0] next_syncA;
  logic [SYNC_COUNT-1:0] next_syncB;
  logic [SYNC_COUNT-1:0] next_syncPrev;

  dev_state_type state;
  dev_state_type next_state;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic [15:0] shiftReg;
  logic [15:0] next_shiftReg;
  logic [15:0] heldCode;
  logic [15:0] next_heldCode;
  logic busyReg;
  logic next_busyReg;
  logic sdoOeReg;
  logic next_sdoOeReg;
  logic compressReg;
  logic next_compressReg;

  logic cnvRise;
  logic sckRise;
  logic porReset;
  logic loadResult;

  // Pins from the host pass two flops before any use
  always_comb begin
    next_syncA = {supplyLow, link.referenceCompressStrapN,
                  link.readSelectN, link.sck, link.conversionStart};
    next_syncB = syncA;
    next_syncPrev = syncB;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      syncA <= SYNC_RESET;
      syncB <= SYNC_RESET;
      syncPrev <= SYNC_RESET;
    end else begin
      syncA <= next_syncA;
      syncB <= next_syncB;
      syncPrev <= next_syncPrev;
    end
  end

  assign cnvRise = syncB[SYNC_CNV] & ~syncPrev[SYNC_CNV];
  assign sckRise = syncB[SYNC_SCK] & ~syncPrev[SYNC_SCK];
  // Low supply acts like power-on reset, except that the strap register keeps following its pin
  assign porReset = !resetn || syncB[SYNC_SUPPLY];

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shiftReg = shiftReg;
    next_heldCode = heldCode;
    next_busyReg = busyReg;
    next_sdoOeReg = ~syncB[SYNC_SEL];
    next_compressReg = ~syncB[SYNC_STRAP];
    loadResult = 1'b0;
    unique case (state)
      ST_INIT: begin
        // Starts during reinitialisation are dropped
        if (cnt == INIT_LAST) begin
          next_state = ST_DOWN;
          next_cnt = COUNT_RESET;
        end else begin
          next_cnt = cnt + 12'h001;
        end
      end
      ST_DOWN: begin
        if (cnvRise) begin
          next_state = ST_CONV;
          next_cnt = COUNT_RESET;
          next_busyReg = 1'b1;
          next_heldCode = scale_code(analogSample,
                                     compressReg);
        end
      end
      ST_CONV: begin
        // Further start edges are not looked at here
        if (cnt == CONV_LAST) begin
          next_state = ST_DOWN;
          next_cnt = COUNT_RESET;
          next_busyReg = 1'b0;
          loadResult = 1'b1;
        end else begin
          next_cnt = cnt + 12'h001;
        end
      end
    endcase
    // Load beats a coincident clock edge so no word is torn
    if (loadResult) begin
      next_shiftReg = heldCode;
    end else if (sckRise) begin
      next_shiftReg = {shiftReg[14:0], 1'b0};
    end
    if (porReset) begin
      next_state = ST_INIT;
      next_cnt = COUNT_RESET;
      next_busyReg = 1'b0;
      next_shiftReg = RESULT_RESET;
      next_heldCode = RESULT_RESET;
      next_sdoOeReg = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= ST_INIT;
      cnt <= COUNT_RESET;
      shiftReg <= RESULT_RESET;
      heldCode <= RESULT_RESET;
      busyReg <= 1'b0;
      sdoOeReg <= 1'b0;
      compressReg <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shiftReg <= next_shiftReg;
      heldCode <= next_heldCode;
      busyReg <= next_busyReg;
      sdoOeReg <= next_sdoOeReg;
      compressReg <= next_compressReg;
    end
  end

  assign link.busy = busyReg;
  // Top bit sits on the line from load until the first edge
  assign link.sdo = shiftReg[15];
  assign link.sdoOe = sdoOeReg;
  assign poweredDown = state[1] | state[0];
  assign acquiring = state[1] |
    (state[2] & (cnt >= ACQ_FROM));
  assign initDone = ~state[0];
  assign gainCompression = compressReg;

endmodule

// File: design/sar_adc_host.sv
// Host end: start pulses, divided serial clock and word buffer
`timescale 1ns/10ps
module sar_adc_host
  import sar_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  sar_link_if.host link,
  input wire logic convRequest,
  input wire logic compressEnable,
  output logic hostReady,
  output logic wordValid,
  input wire logic wordReady,
  output logic [15:0] wordData
);

  logic [1:0] busySync;
  logic [1:0] sdoSync;
  logic [1:0] next_busySync;
  logic [1:0] next_sdoSync;

  host_state_type state;
  host_state_type next_state;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic [2:0] phase;
  logic [2:0] next_phase;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [15:0] rxShift;
  logic [15:0] next_rxShift;
  logic cnvReg;
  logic next_cnvReg;
  logic sckReg;
  logic next_sckReg;
  logic selNReg;
  logic next_selNReg;
  logic strapNReg;
  logic next_strapNReg;

  logic [15:0] fifoMem [2];
  logic [15:0] next_fifoMem [2];
  logic wrPtr;
  logic next_wrPtr;
  logic rdPtr;
  logic next_rdPtr;
  logic [1:0] fifoCount;
  logic [1:0] next_fifoCount;
  logic push;
  logic pop;
  logic fifoFull;

  always_comb begin
    next_busySync = {busySync[0], link.busy};
    next_sdoSync = {sdoSync[0], link.sdoLine};
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busySync <= 2'b00;
      sdoSync <= 2'b00;
    end else begin
      busySync <= next_busySync;
      sdoSync <= next_sdoSync;
    end
  end

  // A full buffer holds off new conversions
  assign fifoFull = fifoCount[1];
  assign hostReady = (state == H_IDLE) & ~fifoFull;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_phase = phase;
    next_bitCnt = bitCnt;
    next_rxShift = rxShift;
    next_cnvReg = cnvReg;
    next_sckReg = sckReg;
    next_selNReg = selNReg;
    next_strapNReg = ~compressEnable;
    push = 1'b0;
    unique case (state)
      H_INIT: begin
        if (cnt == INIT_LAST) begin
          next_state = H_IDLE;
        end else begin
          next_cnt = cnt + 12'h001;
        end
      end
      H_IDLE: begin
        // Clock parked low and output released while idle
        if (convRequest && !fifoFull) begin
          next_state = H_START;
          next_cnvReg = 1'b1;
        end
      end
      H_START: begin
        if (busySync[1]) begin
          next_state = H_CONV;
        end
      end
      H_CONV: begin
        // Start stays high until the conversion is over
        if (!busySync[1]) begin
          next_state = H_READ;
          next_cnvReg = 1'b0;
          next_selNReg = 1'b0;
          next_phase = 3'h0;
          next_bitCnt = 4'h0;
        end
      end
      H_READ: begin
        next_phase = phase + 3'h1;
        if (phase == SCK_FALL_PHASE) begin
          next_sckReg = 1'b0;
        end
        // Sample just before raising the clock: the next edge
        if (phase == SCK_LAST_PHASE) begin
          next_rxShift = {rxShift[14:0], sdoSync[1]};
          next_bitCnt = bitCnt + 4'h1;
          if (bitCnt == LAST_BIT) begin
            next_state = H_IDLE;
            next_selNReg = 1'b1;
            push = 1'b1;
          end else begin
            next_sckReg = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= H_INIT;
      cnt <= COUNT_RESET;
      phase <= 3'h0;
      bitCnt <= 4'h0;
      rxShift <= RESULT_RESET;
      cnvReg <= 1'b0;
      sckReg <= 1'b0;
      selNReg <= 1'b1;
      strapNReg <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      phase <= next_phase;
      bitCnt <= next_bitCnt;
      rxShift <= next_rxShift;
      cnvReg <= next_cnvReg;
      sckReg <= next_sckReg;
      selNReg <= next_selNReg;
      strapNReg <= next_strapNReg;
    end
  end

  assign pop = wordValid & wordReady;

  always_comb begin
    next_fifoMem = fifoMem;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_fifoCount = fifoCount;
    // Last bit joins the word as it is pushed
    if (push) begin
      next_fifoMem[wrPtr] = {rxShift[14:0], sdoSync[1]};
      next_wrPtr = ~wrPtr;
    end
    if (pop) begin
      next_rdPtr = ~rdPtr;
    end
    if (push && !pop) begin
      next_fifoCount = fifoCount + 2'h1;
    end else if (pop && !push) begin
      next_fifoCount = fifoCount - 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fifoMem[0] <= RESULT_RESET;
      fifoMem[1] <= RESULT_RESET;
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      fifoCount <= 2'h0;
    end else begin
      fifoMem <= next_fifoMem;
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      fifoCount <= next_fifoCount;
    end
  end

  assign wordValid = fifoCount != 2'h0;
  assign wordData = fifoMem[rdPtr];
  assign link.conversionStart = cnvReg;
  assign link.sck = sckReg;
  assign link.readSelectN = selNReg;
  assign link.referenceCompressStrapN = strapNReg;

endmodule

// File: sim/sar_link_sva.sv
// Link checker between converter end and host end
`timescale 1ns/10ps
module sar_link_sva
  import sar_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic conversionStart,
  input wire logic sck,
  input wire logic readSelectN,
  input wire logic referenceCompressStrapN,
  input wire logic busy,
  input wire logic sdo,
  input wire logic sdoOe
);
  logic [9:0] busyCount;
  logic [9:0] next_busyCount;
  logic [4:0] riseCount;
  logic [4:0] next_riseCount;
  logic sckLast;
  logic next_sckLast;

  // Counts restart whenever the qualifying level drops
  always_comb begin
    next_busyCount = busy ? busyCount + 10'h001 : 10'h000;
    next_riseCount = readSelectN ? 5'h00 : riseCount + 5'(sck & ~sckLast);
    next_sckLast = sck;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busyCount <= 10'h000;
      riseCount <= 5'h00;
      sckLast <= 1'b0;
    end else begin
      busyCount <= next_busyCount;
      riseCount <= next_riseCount;
      sckLast <= next_sckLast;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  busy_len_a: assert property ($fell(busy) |-> busyCount == 10'(CONV_CYCLES))
    else $error("busy width wrong");
  start_busy_a: assert property ($rose(conversionStart) |-> ##[1:8] busy)
    else $error("start not answered by busy");
  cnv_steady_a: assert property (busy && $past(busy) |-> $stable(conversionStart))
    else $error("start moved during conversion");
  cnv_drop_a: assert property ($fell(busy) |-> ##[1:8] !conversionStart)
    else $error("start not dropped after conversion");
  sck_quiet_a: assert property (busy |-> !sck && readSelectN)
    else $error("readout during conversion");
  sck_count_a: assert property ($rose(readSelectN) |-> riseCount == 5'h0f)
    else $error("wrong number of clock rises");
  sdo_hold_a: assert property (sdoOe && $past(sdoOe) && !sck && $past(!sck)
    && $past(!sck, 2) && !$fell(busy) |-> $stable(sdo))
    else $error("data changed while clock low");
  oe_off_a: assert property (readSelectN [*4] |-> !sdoOe)
    else $error("data driven while deselected");
  oe_on_a: assert property (!readSelectN [*4] |-> sdoOe)
    else $error("data not driven while selected");
endmodule

// File: sim/tb.sv
// Testbench joining converter end and host end over the link
`timescale 1ns/10ps
module tb;
  import sar_pkg::*;
  logic clk_sys;
  logic resetn;
  logic convRequest;
  logic compressEnable;
  logic wordReady;
  logic supplyLow;
  logic [15:0] analogSample;
  logic [15:0] wordData;
  logic hostReady;
  logic wordValid;
  logic poweredDown;
  logic acquiring;
  logic initDone;
  logic gainCompression;
  int bad_count = 0;
  int tests_run = 0;
  int n;

  sar_link_if link();
  sar_adc_device u_sar_adc_device (.clk_sys(clk_sys), .resetn(resetn),
    .link(link), .analogSample(analogSample), .supplyLow(supplyLow),
    .poweredDown(poweredDown), .acquiring(acquiring), .initDone(initDone),
    .gainCompression(gainCompression));
  sar_adc_host u_sar_adc_host (.clk_sys(clk_sys), .resetn(resetn),
    .link(link), .convRequest(convRequest), .compressEnable(compressEnable),
    .hostReady(hostReady), .wordValid(wordValid), .wordReady(wordReady),
    .wordData(wordData));
  sar_link_sva u_sar_link_sva (.clk_sys(clk_sys), .resetn(resetn),
    .conversionStart(link.conversionStart), .sck(link.sck),
    .readSelectN(link.readSelectN),
    .referenceCompressStrapN(link.referenceCompressStrapN),
    .busy(link.busy), .sdo(link.sdo), .sdoOe(link.sdoOe));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task settle(input int c);
    repeat (c) @(negedge clk_sys);
  endtask

  // Sample and strap settle before the request so the start sees them
  task conv(input logic [15:0] s, input logic comp);
    @(negedge clk_sys);
    n = 0;
    while (hostReady !== 1'b1 && n < 6000) begin
      @(negedge clk_sys);
      n++;
    end
    check(16'(hostReady), 16'h0001);
    @(posedge clk_sys);
    analogSample <= s;
    compressEnable <= comp;
    repeat (8) @(posedge clk_sys);
    convRequest <= 1'b1;
    @(posedge clk_sys);
    convRequest <= 1'b0;
    n = 0;
    while (link.busy !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check(16'(gainCompression), 16'(comp));
    check(16'(link.busy), 16'h0001);
    check(16'(poweredDown), 16'h0000);
    check(16'(acquiring), 16'h0000);
    settle(ACQ_CYCLES - 1);
    check(16'(acquiring), 16'h0000);
    settle(1);
    check(16'(acquiring), 16'h0001);
    settle(CONV_CYCLES - ACQ_CYCLES - 1);
    check(16'(link.busy), 16'h0001);
    settle(1);
    check(16'(link.busy), 16'h0000);
    check(16'(poweredDown), 16'h0001);
    check(16'(acquiring), 16'h0001);
  endtask

  task pop(input logic [15:0] exp);
    // Step off the edge so a pop just made has settled
    @(negedge clk_sys);
    n = 0;
    while (wordValid !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    check(wordData, exp);
    @(posedge clk_sys);
    wordReady <= 1'b1;
    @(posedge clk_sys);
    wordReady <= 1'b0;
  endtask

  initial begin
    resetn = 1'b0;
    convRequest = 1'b0;
    compressEnable = 1'b0;
    wordReady = 1'b0;
    supplyLow = 1'b0;
    analogSample = 16'h0000;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    settle(2);
    check(16'(initDone), 16'h0000);
    check(16'(poweredDown), 16'h0001);
    check(16'(hostReady), 16'h0000);
    conv(16'h1234, 1'b0);
    pop(16'h1234);
    conv(16'h7fff, 1'b0);
    pop(16'h7fff);
    conv(16'h8000, 1'b0);
    pop(16'h8000);
    conv(16'h1000, 1'b1);
    pop(16'h1400);
    conv(16'h7000, 1'b1);
    pop(16'h7fff);
    conv(16'hfc00, 1'b1);
    pop(16'hfb00);
    // Two words wait in the buffer while the user side stalls
    conv(16'h0001, 1'b0);
    conv(16'hffff, 1'b0);
    settle(200);
    check(16'(wordValid), 16'h0001);
    check(16'(hostReady), 16'h0000);
    pop(16'h0001);
    pop(16'hffff);
    settle(2);
    check(16'(wordValid), 16'h0000);
    @(posedge clk_sys);
    supplyLow <= 1'b1;
    repeat (4) @(posedge clk_sys);
    supplyLow <= 1'b0;
    settle(2);
    check(16'(initDone), 16'h0000);
    check(16'(poweredDown), 16'h0001);
    settle(3900);
    check(16'(initDone), 16'h0000);
    settle(200);
    check(16'(initDone), 16'h0001);
    conv(16'h4321, 1'b0);
    pop(16'h4321);
    end_sim;
  end

  initial begin
    #200000;
    bad_count++;
    end_sim;
  end
endmodule
